// *** rtl/acc_pkg.sv ***
// Constants shared by the conversion clock and start control block.
// Assumes a 32-bit classic Wishbone register bus on the system clock.
package acc_pkg;

    // ========================================================================
    // Register byte offsets
    localparam logic [7:0] ACC_OFS_CLOCK_SETTING  = 8'h00;
    localparam logic [7:0] ACC_OFS_START_CONTROL  = 8'h04;
    localparam logic [7:0] ACC_OFS_TRIGGER_CTRL   = 8'h08;
    localparam logic [7:0] ACC_OFS_STATUS         = 8'h80;

    // ========================================================================
    // Field positions
    localparam int ACC_SH_LSB       = 4;     // Sample-hold code, bits 7:4
    localparam int ACC_DIV_LSB      = 0;     // Prescaler code, bits 2:0
    localparam int ACC_NORMAL_BIT   = 0;     // Normal start, write only
    localparam int ACC_PRIO_BIT     = 1;     // Priority start, write only
    localparam int ACC_NORM_HW_BIT  = 0;     // Normal on external trigger
    localparam int ACC_PRIO_HW_BIT  = 2;     // Priority on external trigger
    localparam int ACC_REF_ON_BIT   = 7;     // Reference power control
    localparam int ACC_BUSY_BIT     = 0;
    localparam int ACC_PRIO_RUN_BIT = 1;
    localparam int ACC_SAMPLE_BIT   = 2;

    // ========================================================================
    // Reset values
    localparam logic [3:0] ACC_SH_RESET  = 4'h0;
    localparam logic [2:0] ACC_DIV_RESET = 3'h0;

    // ========================================================================
    // Timing in conversion clocks
    localparam logic [6:0] ACC_SH_10       = 7'h0A;
    localparam logic [6:0] ACC_SH_20       = 7'h14;
    localparam logic [6:0] ACC_SH_30       = 7'h1E;
    localparam logic [6:0] ACC_SH_40       = 7'h28;
    localparam logic [6:0] ACC_SH_80       = 7'h50;
    localparam logic [6:0] ACC_CONV_REST   = 7'h1E;  // Clocks after sample-hold
    localparam logic [6:0] ACC_MIN_TOTAL   = 7'h28;  // Least conversion length
    localparam logic [2:0] ACC_DIV_MAX_SEL = 3'h3;   // Largest legal prescaler code

    // ========================================================================
    // Conversion sequence, Gray coded along idle-sample-convert-done
    typedef enum logic [1:0] {
        ACC_IDLE    = 2'b00,
        ACC_SAMPLE  = 2'b01,
        ACC_CONVERT = 2'b11,
        ACC_DONE    = 2'b10
    } acc_state_t;

endpackage

// *** rtl/acc_prescaler.sv ***
// Prescaler that turns the system clock into conversion clock enables.
// Assumes the select code is static while a conversion runs.
`timescale 1ns/100ps
`default_nettype none

module acc_prescaler
    import acc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       clear_i,
    input  wire logic [2:0] div_sel_i,
    output logic            tick_o
);

    // ========================================================================
    // Divider count
    logic [2:0] count;
    logic [2:0] next_count;
    logic [2:0] limit;
    logic [2:0] sel_eff;

    // Reserved codes fall back to the slowest legal rate, the safe side
    always_comb begin
        sel_eff    = (div_sel_i > ACC_DIV_MAX_SEL) ? ACC_DIV_MAX_SEL : div_sel_i;
        limit      = 3'((4'h1 << sel_eff) - 4'h1);
        tick_o     = (count >= limit);  // A raised rate ticks at once rather than wrapping the count
        next_count = (clear_i || tick_o) ? 3'h0 : 3'(count + 3'h1);
    end

    // Registers only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 3'h0;
        end else begin
            count <= next_count;
        end
    end

endmodule

`default_nettype wire

// *** rtl/acc_conv_ctrl.sv ***
// Conversion clock and start control: registers, triggers, sequence timing.
// Assumes a classic Wishbone master and an asynchronous trigger pin.
//
// How it works
// - Sample-hold code picks 10,20,30,40,80 clocks
// - Prescaler code divides system clock 1,2,4,8
// - Every conversion lasts at least forty conversion clocks
// - Priority start write one launches, reads zero
// - Normal start write one launches when idle, reads zero
// - Trigger with both armed starts priority only
`timescale 1ns/100ps
`default_nettype none

module acc_conv_ctrl
    import acc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        external_trigger_pin_i,
    output logic             reference_power_on_o,
    output logic             conv_tick_o,
    output logic             priority_start_o,
    output logic             normal_start_o,
    output logic             sample_hold_o,
    output logic             conv_busy_o,
    output logic             conv_done_o
);

    // ========================================================================
    // Declarations
    logic [3:0]  sh_sel;
    logic [3:0]  next_sh_sel;
    logic [2:0]  div_sel;
    logic [2:0]  next_div_sel;
    logic        ref_on;
    logic        next_ref_on;
    logic        prio_hw_en;
    logic        next_prio_hw_en;
    logic        norm_hw_en;
    logic        next_norm_hw_en;
    logic [31:0] next_dat;
    logic        next_ack;
    logic        wr_now;
    logic        sw_prio;
    logic        sw_norm;
    logic        next_prio_start;
    logic        next_norm_start;
    logic [2:0]  trg_sync;
    logic        trg_edge;
    acc_state_t  state;
    acc_state_t  next_state;
    logic [6:0]  count;
    logic [6:0]  next_count;
    logic        prio_run;
    logic        next_prio_run;
    logic        next_done;
    logic [6:0]  sh_len;
    logic        tick;
    logic        start_any;

    // ========================================================================
    // Prescaler, restarted on each launch so the first conversion clock is whole
    acc_prescaler u_prescaler (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clear_i   (start_any),
        .div_sel_i (div_sel),
        .tick_o    (tick)
    );

    // ========================================================================
    // Register bus; a write lands on the edge where ack is high
    always_comb begin
        wr_now          = cyc_i && stb_i && we_i && ack_o;
        next_ack        = cyc_i && stb_i && !ack_o;
        next_sh_sel     = sh_sel;
        next_div_sel    = div_sel;
        next_ref_on     = ref_on;
        next_prio_hw_en = prio_hw_en;
        next_norm_hw_en = norm_hw_en;
        sw_prio         = 1'b0;
        sw_norm         = 1'b0;
        next_dat        = dat_o;
        if (wr_now && sel_i[0]) begin
            case (adr_i)
                ACC_OFS_CLOCK_SETTING: begin
                    next_sh_sel  = dat_i[ACC_SH_LSB +: 4];
                    next_div_sel = dat_i[ACC_DIV_LSB +: 3];
                end
                ACC_OFS_START_CONTROL: begin
                    sw_prio = dat_i[ACC_PRIO_BIT];
                    sw_norm = dat_i[ACC_NORMAL_BIT];
                end
                ACC_OFS_TRIGGER_CTRL: begin
                    next_ref_on     = dat_i[ACC_REF_ON_BIT];
                    next_prio_hw_en = dat_i[ACC_PRIO_HW_BIT];
                    next_norm_hw_en = dat_i[ACC_NORM_HW_BIT];
                end
                default: begin
                end
            endcase
        end
        // Read data is captured as ack rises and held through the ack cycle
        if (next_ack) begin
            next_dat = 32'h0000_0000;
            case (adr_i)
                ACC_OFS_CLOCK_SETTING: begin
                    next_dat[ACC_SH_LSB +: 4]  = sh_sel;
                    next_dat[ACC_DIV_LSB +: 3] = div_sel;
                end
                ACC_OFS_TRIGGER_CTRL: begin
                    next_dat[ACC_REF_ON_BIT]  = ref_on;
                    next_dat[ACC_PRIO_HW_BIT] = prio_hw_en;
                    next_dat[ACC_NORM_HW_BIT] = norm_hw_en;
                end
                ACC_OFS_STATUS: begin
                    next_dat[ACC_BUSY_BIT]     = conv_busy_o;
                    next_dat[ACC_PRIO_RUN_BIT] = prio_run;
                    next_dat[ACC_SAMPLE_BIT]   = sample_hold_o;
                end
                default: begin
                    next_dat = 32'h0000_0000;  // Start bits and unmapped space read zero
                end
            endcase
        end
    end

    // ========================================================================
    // Trigger edge; stage one is only read by stage two
    always_comb begin
        trg_edge = trg_sync[1] && !trg_sync[2];
        // Priority takes the trigger outright when both are armed
        next_prio_start = sw_prio || (trg_edge && prio_hw_en);
        next_norm_start = sw_norm || (trg_edge && norm_hw_en && !prio_hw_en);
        start_any       = priority_start_o || normal_start_o;
    end

    // ========================================================================
    // Conversion sequence timing in conversion clocks
    always_comb begin
        case (sh_sel)
            4'h0:    sh_len = ACC_SH_10;
            4'h1:    sh_len = ACC_SH_20;
            4'h2:    sh_len = ACC_SH_30;
            4'h3:    sh_len = ACC_SH_40;
            default: sh_len = ACC_SH_80;  // Reserved codes take the longest hold
        endcase
        next_state    = state;
        next_count    = count;
        next_prio_run = prio_run;
        next_done     = 1'b0;
        // A priority start preempts; a normal start is dropped unless idle
        if (priority_start_o || (normal_start_o && state == ACC_IDLE)) begin
            next_state    = ACC_SAMPLE;
            next_count    = 7'h00;
            next_prio_run = priority_start_o;
        end else begin
            case (state)
                ACC_IDLE: begin
                    next_count = 7'h00;
                end
                ACC_SAMPLE: begin
                    if (tick) begin
                        next_count = 7'(count + 7'h01);
                        if (next_count == sh_len) begin
                            next_state = ACC_CONVERT;
                        end
                    end
                end
                ACC_CONVERT: begin
                    // Hold plus rest never drops under the least length
                    if (tick) begin
                        next_count = 7'(count + 7'h01);
                        if (next_count >= 7'(sh_len + ACC_CONV_REST) && next_count >= ACC_MIN_TOTAL) begin
                            next_state = ACC_DONE;
                        end
                    end
                end
                ACC_DONE: begin
                    next_state    = ACC_IDLE;
                    next_done     = 1'b1;
                    next_prio_run = 1'b0;
                end
                default: begin
                    next_state = ACC_IDLE;
                end
            endcase
        end
    end

    // ========================================================================
    // Registers only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_sel           <= ACC_SH_RESET;
            div_sel          <= ACC_DIV_RESET;
            ref_on           <= 1'b0;
            prio_hw_en       <= 1'b0;
            norm_hw_en       <= 1'b0;
            dat_o            <= 32'h0000_0000;
            ack_o            <= 1'b0;
            trg_sync         <= 3'h0;
            priority_start_o <= 1'b0;
            normal_start_o   <= 1'b0;
            state            <= ACC_IDLE;
            count            <= 7'h00;
            prio_run         <= 1'b0;
            conv_done_o      <= 1'b0;
        end else begin
            sh_sel           <= next_sh_sel;
            div_sel          <= next_div_sel;
            ref_on           <= next_ref_on;
            prio_hw_en       <= next_prio_hw_en;
            norm_hw_en       <= next_norm_hw_en;
            dat_o            <= next_dat;
            ack_o            <= next_ack;
            trg_sync         <= {trg_sync[1:0], external_trigger_pin_i};
            priority_start_o <= next_prio_start;
            normal_start_o   <= next_norm_start;
            state            <= next_state;
            count            <= next_count;
            prio_run         <= next_prio_run;
            conv_done_o      <= next_done;
        end
    end

    // ========================================================================
    // Status outputs
    assign reference_power_on_o = ref_on;
    assign conv_tick_o          = tick;
    assign sample_hold_o        = (state == ACC_SAMPLE);
    assign conv_busy_o          = (state != ACC_IDLE);

endmodule

`default_nettype wire

// *** tb/acc_conv_ctrl_sva.sv ***
// Checker for the conversion clock and start control block.
// Assumes it is bound to acc_conv_ctrl and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module acc_sva_chk
    import acc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        external_trigger_pin_i,
    input wire logic        reference_power_on_o,
    input wire logic        conv_tick_o,
    input wire logic        priority_start_o,
    input wire logic        normal_start_o,
    input wire logic        sample_hold_o,
    input wire logic        conv_busy_o,
    input wire logic        conv_done_o
);
    // ========================================================================
    // Helper state
    logic [7:0] trg;
    logic [7:0] tcnt;
    logic       req;
    logic       wr_go;
    logic       sw_norm;

    // Bus requests not yet answered
    assign req     = cyc_i && stb_i && !ack_o;
    assign wr_go   = req && we_i && sel_i[0] && adr_i == ACC_OFS_START_CONTROL;
    assign sw_norm = wr_go && dat_i[ACC_NORMAL_BIT];

    // Mirror trigger enables; count ticks since the last start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trg  <= 8'h00;
            tcnt <= 8'h00;
        end else begin
            if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == ACC_OFS_TRIGGER_CTRL) begin
                trg <= dat_i[7:0];
            end
            // A normal start while busy is dropped, so it must not restart the count
            if (priority_start_o || (normal_start_o && !conv_busy_o)) begin
                tcnt <= 8'h00;
            end else if (conv_busy_o && conv_tick_o && tcnt != 8'hFF) begin
                tcnt <= tcnt + 8'h01;
            end
        end
    end

    // ========================================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_start_reads_zero: assert property (
        req && !we_i && adr_i == ACC_OFS_START_CONTROL |=> ack_o && dat_o == 32'h0000_0000)
        else $error("start control read not zero");
    a_rsvd_zero: assert property (
        req && !we_i && adr_i == ACC_OFS_CLOCK_SETTING |=> ack_o && dat_o[31:8] == 24'h00_0000 && !dat_o[3])
        else $error("clock setting reserved bits set");
    a_prio_launch: assert property (
        wr_go && dat_i[ACC_PRIO_BIT] |=> ##1 priority_start_o)
        else $error("priority start missing");
    a_norm_launch: assert property (
        sw_norm |=> ##1 normal_start_o)
        else $error("normal start missing");
    a_zero_quiet: assert property (
        wr_go && dat_i[1:0] == 2'h0 |=> ##1 !priority_start_o && !normal_start_o)
        else $error("zero write started a conversion");
    a_single_pulse: assert property (
        priority_start_o || normal_start_o |=> !priority_start_o && !normal_start_o)
        else $error("start request longer than one cycle");
    a_min_length: assert property (
        conv_done_o |-> tcnt >= 8'h28)
        else $error("conversion shorter than forty clocks");
    a_prio_wins: assert property (
        normal_start_o && trg[ACC_PRIO_HW_BIT] && trg[ACC_NORM_HW_BIT] |-> $past(sw_norm, 2))
        else $error("trigger started a normal conversion");
endmodule
`default_nettype wire

// *** tb/test_acc_conv_ctrl.sv ***
// Self-checking bench for the conversion clock and start control block.
// Assumes the package and the checker file are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module test_acc_conv_ctrl
    import acc_pkg::*;
;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, external_trigger_pin_i;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic        ack_o, reference_power_on_o, conv_tick_o, priority_start_o, normal_start_o;
    logic        sample_hold_o, conv_busy_o, conv_done_o;
    int          fail_count, checks, np, nn, nd, tk, sh_t, cv_t;

    acc_conv_ctrl acc_conv_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .external_trigger_pin_i(external_trigger_pin_i), .reference_power_on_o(reference_power_on_o),
        .conv_tick_o(conv_tick_o), .priority_start_o(priority_start_o), .normal_start_o(normal_start_o),
        .sample_hold_o(sample_hold_o), .conv_busy_o(conv_busy_o), .conv_done_o(conv_done_o));

    // ========================================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic cycle held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Counters are cleared off the edge so the monitor never races
    task automatic clr();
        @(negedge clk_i);
        {np, nn, nd, tk, sh_t, cv_t} = '0;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (nd == 0 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        if (nd == 0) fail_count++;
        @(posedge clk_i);
    endtask

    // Pin pulse with given trigger enables; reference stays on
    task automatic trig(input logic [31:0] t, input int ep, input int en);
        wb(1'b1, ACC_OFS_TRIGGER_CTRL, t);
        clr();
        @(posedge clk_i);
        external_trigger_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        external_trigger_pin_i <= 1'b0;
        wait_done();
        chk(np, ep);
        chk(nn, en);
    endtask

    function automatic int sh_len(input logic [3:0] c);
        return (c < 4'h4) ? 10 * (c + 1) : 80;
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ========================================================================
    // Clock, monitor and watchdog
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Count pulses and conversion ticks seen at the outputs
    always @(posedge clk_i) begin
        np += priority_start_o;
        nn += normal_start_o;
        nd += conv_done_o;
        tk += conv_tick_o;
        sh_t += (sample_hold_o && conv_tick_o);
        cv_t += (conv_busy_o && conv_tick_o);
    end

    // More than five times the expected run length
    initial begin
        #400_000;
        fail_count++;
        final_report();
    end

    // ========================================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        {rst_i, cyc_i, stb_i, we_i, external_trigger_pin_i} = 5'h10;
        {adr_i, dat_i, sel_i} = {8'h00, 32'h0000_0000, 4'hF};
        {fail_count, checks} = '0;
        void'($urandom(82));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        wb(1'b0, ACC_OFS_CLOCK_SETTING, 32'h0);
        chk(q, 32'h0000_0000);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0000_0000);
        // Random settings read back with reserved bits cleared
        repeat (6) begin
            r = $urandom;
            wb(1'b1, ACC_OFS_CLOCK_SETTING, r);
            wb(1'b0, ACC_OFS_CLOCK_SETTING, 32'h0);
            chk(q, r & 32'h0000_00F7);
        end
        // A write without byte lane zero is ignored
        sel_i <= 4'hE;
        wb(1'b1, ACC_OFS_CLOCK_SETTING, 32'h0000_00FF);
        sel_i <= 4'hF;
        wb(1'b0, ACC_OFS_CLOCK_SETTING, 32'h0);
        chk(q, r & 32'h0000_00F7);
        // Every prescaler code over a 64-cycle window
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, ACC_OFS_CLOCK_SETTING, 32'(c));
            clr();
            repeat (64) @(negedge clk_i);
            chk(tk, 64 >> (c > 3 ? 3 : c));
            @(posedge clk_i);
        end
        // Settings change only with reference off, then settle 3 us
        for (int s = 0; s < 6; s++) begin
            r = $urandom_range(1);
            wb(1'b1, ACC_OFS_TRIGGER_CTRL, 32'h0);
            chk(reference_power_on_o, 32'h0);
            wb(1'b1, ACC_OFS_CLOCK_SETTING, 32'({s[3:0], 3'b001, r[0]}));
            wb(1'b1, ACC_OFS_TRIGGER_CTRL, 32'h80);
            wb(1'b0, ACC_OFS_TRIGGER_CTRL, 32'h0);
            chk(q, 32'h0000_0080);
            chk(reference_power_on_o, 32'h1);
            repeat (300) @(posedge clk_i);
            clr();
            @(posedge clk_i);
            wb(1'b1, ACC_OFS_START_CONTROL, 32'h0);
            wb(1'b1, ACC_OFS_START_CONTROL, (s % 2) ? 32'h2 : 32'h1);
            // Status is read early in the hold phase, which lasts at least forty cycles here
            wb(1'b0, ACC_OFS_STATUS, 32'h0);
            chk(q, (s % 2) ? 32'h0000_0007 : 32'h0000_0005);
            wait_done();
            chk(np, s % 2);
            chk(nn, 1 - s % 2);
            chk(sh_t, sh_len(s[3:0]));
            chk(cv_t >= 40, 1);
            wb(1'b0, ACC_OFS_START_CONTROL, 32'h0);
            chk(q, 32'h0000_0000);
        end
        trig(32'h85, 1, 0);
        trig(32'h81, 0, 1);
        final_report();
    end
endmodule

bind acc_conv_ctrl acc_sva_chk acc_sva_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .external_trigger_pin_i(external_trigger_pin_i), .reference_power_on_o(reference_power_on_o),
    .conv_tick_o(conv_tick_o), .priority_start_o(priority_start_o), .normal_start_o(normal_start_o),
    .sample_hold_o(sample_hold_o), .conv_busy_o(conv_busy_o), .conv_done_o(conv_done_o));
`default_nettype wire
